// ---- mdmac_arb.sv ----
// Purpose: shared constants and the channel arbiter of the dma controller
// Assumes: one clock, pclk; all inputs synchronous to it
// Notes: the package sits here so the design stays in two files
`timescale 1ns/10ps

package mdmac_pkg;
    // ------------------------------------------------------------
    // sizes and register offsets
    // ------------------------------------------------------------
    localparam int NCH = 32;
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_BASE = 8'h04;
    localparam logic [7:0] REG_ALTBASE = 8'h08;
    localparam logic [7:0] REG_SWREQ = 8'h0C;
    localparam logic [7:0] REG_MASK_SET = 8'h10;
    localparam logic [7:0] REG_MASK_CLR = 8'h14;
    localparam logic [7:0] REG_PRIO_SET = 8'h18;
    localparam logic [7:0] REG_PRIO_CLR = 8'h1C;
    localparam logic [7:0] REG_ALT_SET = 8'h20;
    localparam logic [7:0] REG_ALT_CLR = 8'h24;
    localparam logic [7:0] REG_ENA_SET = 8'h28;
    localparam logic [7:0] REG_ENA_CLR = 8'h2C;
    localparam logic [7:0] REG_ERR = 8'h30;
    localparam logic [7:0] REG_STAT = 8'h34;
    localparam logic [7:0] REG_REMAIN = 8'h38;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [21:0] RST_BASE = 22'h00_0000;
    // ------------------------------------------------------------
    // control table layout: 64 entries of 16 bytes
    // ------------------------------------------------------------
    localparam int BASE_LSB = 10;
    localparam logic [31:0] ALT_OFFSET = 32'h0000_0200;
    localparam logic [3:0] DESC_SRC = 4'h0;
    localparam logic [3:0] DESC_DST = 4'h4;
    localparam logic [3:0] DESC_CTL = 4'h8;
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_CNT_LSB = 4;
    localparam int CTL_SIZE_LSB = 24;
    localparam int CTL_SINC_LSB = 26;
    localparam int CTL_DINC_LSB = 30;
    localparam logic [1:0] INC_NONE = 2'h3;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [10:0] CNT_ZERO = 11'h000;
    localparam logic [10:0] CNT_ONE = 11'h001;

    typedef enum logic [2:0] {
        MODE_STOP = 3'h0,
        MODE_BASIC = 3'h1,
        MODE_AUTO = 3'h2,
        MODE_PINGPONG = 3'h3,
        MODE_MEM_SG = 3'h4,
        MODE_PER_SG = 3'h5
    } mdmac_mode_e;

    // address step for one item; none keeps the pointer still
    function automatic logic [31:0] mdmac_step(logic [1:0] inc);
        return (inc == INC_NONE) ? 32'h0000_0000 : (32'h0000_0001 << inc);
    endfunction
endpackage

// picks the lowest pending channel, high-priority group first
module mdmac_arb
    import mdmac_pkg::*;
(
    input wire logic [31:0] pend,
    input wire logic [31:0] prio,
    output logic valid,
    output logic [4:0] chan
);
    // ------------------------------------------------------------
    // priority encoder
    // ------------------------------------------------------------
    logic [31:0] hi_pend;
    logic [31:0] pick_vec;

    assign hi_pend = pend & prio;
    assign pick_vec = (hi_pend != RST_WORD) ? hi_pend : pend;
    assign valid = (pend != RST_WORD);

    // lowest set bit wins; a loop keeps it compact
    always_comb begin
        chan = 5'h00;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (pick_vec[i]) begin
                chan = 5'(i);
            end
        end
    end
endmodule // mdmac_arb

// ---- mdmac_top.sv ----
// Purpose: multichannel dma controller, apb registers plus memory master
// Assumes: memory bus holds request until ack; err is valid with ack
// Notes: one channel moves at a time, one item per read/write pair
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/10ps

module mdmac_top
    import mdmac_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic [1:0] mem_size,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic [31:0] dma_req,
    output logic [31:0] periph_done,
    output logic irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [8:0] {
        S_IDLE = 9'h001,
        S_RD_CTL = 9'h002,
        S_RD_SRC = 9'h004,
        S_RD_DST = 9'h008,
        S_RD_DATA = 9'h010,
        S_WR_DATA = 9'h020,
        S_WB_SRC = 9'h040,
        S_WB_DST = 9'h080,
        S_WB_CTL = 9'h100
    } mdmac_state_e;

    mdmac_state_e state;
    logic glob_en;
    logic [21:0] base_hi;
    logic [31:0] ena;
    logic [31:0] req_mask;
    logic [31:0] prio;
    logic [31:0] alt_sel;
    logic [31:0] sw_pend;
    logic err_flag;
    logic [4:0] ch;
    logic cur_alt;
    logic from_sw;
    mdmac_mode_e cur_mode;
    logic [31:0] src_ptr;
    logic [31:0] dst_ptr;
    logic [31:0] ctl;
    logic [31:0] data_buf;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic wr_en;
    logic [31:0] rd_mux;
    logic addr_ok;

    // write lands only on the completing access edge
    assign wr_en = psel & penable & pready & pwrite;
    assign addr_ok = (paddr <= REG_REMAIN) && (paddr[1:0] == 2'h0);

    // read view of state; reserved bits read zero
    assign rd_mux =
        (paddr == REG_CFG) ? {30'h0, ~state[0], glob_en} :
        (paddr == REG_BASE) ? {base_hi, 10'h000} :
        (paddr == REG_ALTBASE) ? ({base_hi, 10'h000} | ALT_OFFSET) :
        (paddr == REG_SWREQ) ? sw_pend :
        (paddr == REG_MASK_SET) ? req_mask :
        (paddr == REG_PRIO_SET) ? prio :
        (paddr == REG_ALT_SET) ? alt_sel :
        (paddr == REG_ENA_SET) ? ena :
        (paddr == REG_ERR) ? {31'h0, err_flag} :
        (paddr == REG_STAT) ? {23'h0, cur_alt, 3'h0, ch} :
        (paddr == REG_REMAIN) ?
            {13'h0000, cur_mode, ch, ctl[CTL_CNT_LSB +: 11]} :
        RST_WORD;

    // one wait-free access phase: ready raised by the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= RST_WORD;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            prdata <= (psel & ~penable & ~pwrite) ? rd_mux : RST_WORD;
            pslverr <= psel & ~penable & ~addr_ok;
        end
    end

    // ------------------------------------------------------------
    // per-register write strobes
    // ------------------------------------------------------------
    function automatic logic [31:0] wmask(logic [7:0] off);
        return (wr_en && paddr == off) ? pwdata : RST_WORD;
    endfunction

    logic [31:0] sw_set_ena;
    logic [31:0] sw_clr_ena;
    logic [31:0] sw_req_set;
    logic err_clr;

    assign sw_set_ena = wmask(REG_ENA_SET);
    assign sw_clr_ena = wmask(REG_ENA_CLR);
    assign sw_req_set = wmask(REG_SWREQ);
    assign err_clr = wmask(REG_ERR) != RST_WORD;

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    logic [31:0] hw_req;
    logic [31:0] pend;
    logic arb_valid;
    logic [4:0] arb_ch;

    // masked peripheral requests plus software requests
    assign hw_req = dma_req & ~req_mask;
    assign pend = ena & (hw_req | sw_pend);

    mdmac_arb u_arb (
        .pend(pend),
        .prio(prio),
        .valid(arb_valid),
        .chan(arb_ch)
    );

    // ------------------------------------------------------------
    // descriptor fields and memory addressing
    // ------------------------------------------------------------
    logic [10:0] cnt;
    logic [1:0] item_size;
    logic [31:0] src_step;
    logic [31:0] dst_step;
    logic [31:0] desc_addr;
    logic [31:0] wb_ctl;
    logic acked;
    logic start;
    logic stop_mode;
    logic last_item;
    logic keep_going;
    logic req_live;
    logic chain_mode;

    assign cnt = ctl[CTL_CNT_LSB +: 11];
    assign item_size = ctl[CTL_SIZE_LSB +: 2];
    assign src_step = mdmac_step(ctl[CTL_SINC_LSB +: 2]);
    assign dst_step = mdmac_step(ctl[CTL_DINC_LSB +: 2]);
    // table index is {alternate, channel}: alt entries sit at 32..63
    assign desc_addr = {base_hi, cur_alt, ch, 4'h0};
    // a finished structure goes back with mode stopped, count zero
    assign wb_ctl = (cnt == CNT_ZERO) ?
        {ctl[31:3], MODE_STOP} : ctl;
    assign acked = mem_req & mem_ack;
    assign start = (state == S_IDLE) & glob_en & arb_valid & ~mem_req;
    assign stop_mode = mem_rdata[CTL_MODE_LSB +: 3] == MODE_STOP;
    assign last_item = (cnt == CNT_ONE);
    // software starts count as a held request
    assign req_live = from_sw | hw_req[ch];
    assign keep_going = glob_en & ena[ch] &
        ((cur_mode != MODE_BASIC) | req_live);
    assign chain_mode = (cur_mode == MODE_PINGPONG) |
        (cur_mode == MODE_MEM_SG) | (cur_mode == MODE_PER_SG);

    // ------------------------------------------------------------
    // completion and error events
    // ------------------------------------------------------------
    logic done_evt;
    logic stopped_evt;
    logic err_evt;
    logic [31:0] ch_bit;
    logic [31:0] hw_clr_ena;
    logic [31:0] hw_clr_req;

    assign ch_bit = 32'h0000_0001 << ch;
    assign err_evt = acked & mem_err;
    assign done_evt = acked & ~mem_err & (state == S_WB_CTL) &
        (cnt == CNT_ZERO);
    // a stopped entry at fetch ends a ping-pong or task chain
    assign stopped_evt = acked & ~mem_err & (state == S_RD_CTL) & stop_mode;
    // chain modes stay enabled to fetch the other structure
    assign hw_clr_ena = (err_evt | stopped_evt |
        (done_evt & ~chain_mode)) ? ch_bit : RST_WORD;
    assign hw_clr_req = start ? (32'h0000_0001 << arb_ch) : RST_WORD;

    // ------------------------------------------------------------
    // configuration and attribute registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            glob_en <= 1'b0;
            base_hi <= RST_BASE;
            req_mask <= RST_WORD;
            prio <= RST_WORD;
        end else begin
            if (wr_en && paddr == REG_CFG) begin
                glob_en <= pwdata[0];
            end
            if (wr_en && paddr == REG_BASE) begin
                base_hi <= pwdata[31:BASE_LSB];
            end
            req_mask <= (req_mask | wmask(REG_MASK_SET)) &
                ~wmask(REG_MASK_CLR);
            prio <= (prio | wmask(REG_PRIO_SET)) & ~wmask(REG_PRIO_CLR);
        end
    end

    // hardware and software share these; sets win over clears, except in alt_sel, where REG_ALT_CLR wins over REG_ALT_SET
    logic [31:0] alt_flip;
    assign alt_flip = (done_evt & chain_mode) ? ch_bit : RST_WORD;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ena <= RST_WORD;
            sw_pend <= RST_WORD;
            alt_sel <= RST_WORD;
            err_flag <= 1'b0;
        end else begin
            ena <= (ena & ~sw_clr_ena & ~hw_clr_ena) | sw_set_ena;
            sw_pend <= (sw_pend & ~hw_clr_req) | sw_req_set;
            // after basic or auto the channel falls back to primary
            alt_sel <= (((alt_sel ^ alt_flip) &
                ~((done_evt & ~chain_mode) ? ch_bit : RST_WORD)) |
                wmask(REG_ALT_SET)) & ~wmask(REG_ALT_CLR);
            err_flag <= (err_flag & ~err_clr) | err_evt;
        end
    end

    // ------------------------------------------------------------
    // interrupt outputs
    // ------------------------------------------------------------
    // completions pulse once and need no acknowledging; an error holds irq until a nonzero write to REG_ERR
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
            periph_done <= RST_WORD;
        end else begin
            irq <= ((err_flag & ~err_clr) | err_evt) |
                (done_evt & from_sw);
            periph_done <= (done_evt & ~from_sw) ?
                ch_bit : RST_WORD;
        end
    end

    // ------------------------------------------------------------
    // memory request issue
    // ------------------------------------------------------------
    logic [31:0] next_addr;
    logic [31:0] next_wdata;
    logic next_we;
    logic issue;

    // one idle cycle after each ack keeps the request logic simple
    assign issue = ~mem_req & (state != S_IDLE);
    assign next_addr =
        (state == S_RD_CTL) ? (desc_addr | {28'h0, DESC_CTL}) :
        (state == S_RD_SRC) ? (desc_addr | {28'h0, DESC_SRC}) :
        (state == S_RD_DST) ? (desc_addr | {28'h0, DESC_DST}) :
        (state == S_RD_DATA) ? src_ptr :
        (state == S_WR_DATA) ? dst_ptr :
        (state == S_WB_SRC) ? (desc_addr | {28'h0, DESC_SRC}) :
        (state == S_WB_DST) ? (desc_addr | {28'h0, DESC_DST}) :
        (desc_addr | {28'h0, DESC_CTL});
    assign next_wdata =
        (state == S_WR_DATA) ? data_buf :
        (state == S_WB_SRC) ? src_ptr :
        (state == S_WB_DST) ? dst_ptr : wb_ctl;
    assign next_we = (state == S_WR_DATA) | (state == S_WB_SRC) |
        (state == S_WB_DST) | (state == S_WB_CTL);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= RST_WORD;
            mem_wdata <= RST_WORD;
            mem_size <= SIZE_WORD;
        end else if (issue) begin
            mem_req <= 1'b1;
            mem_we <= next_we;
            mem_addr <= next_addr;
            mem_wdata <= next_wdata;
            mem_size <= ((state == S_RD_DATA) | (state == S_WR_DATA)) ?
                item_size : SIZE_WORD;
        end else if (acked) begin
            mem_req <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // channel engine
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
            ch <= 5'h00;
            cur_alt <= 1'b0;
            from_sw <= 1'b0;
            cur_mode <= MODE_STOP;
            src_ptr <= RST_WORD;
            dst_ptr <= RST_WORD;
            ctl <= RST_WORD;
            data_buf <= RST_WORD;
        end else if (start) begin
            ch <= arb_ch;
            cur_alt <= alt_sel[arb_ch];
            from_sw <= sw_pend[arb_ch];
            state <= S_RD_CTL;
        end else if (err_evt) begin
            state <= S_IDLE;
        end else if (acked) begin
            unique case (state)
                S_RD_CTL: begin
                    ctl <= mem_rdata;
                    cur_mode <= mdmac_mode_e'(mem_rdata[2:0]);
                    state <= stop_mode ? S_IDLE : S_RD_SRC;
                end
                S_RD_SRC: begin
                    src_ptr <= mem_rdata;
                    state <= S_RD_DST;
                end
                S_RD_DST: begin
                    dst_ptr <= mem_rdata;
                    state <= (cnt == CNT_ZERO) ? S_WB_CTL : S_RD_DATA;
                end
                S_RD_DATA: begin
                    data_buf <= mem_rdata;
                    state <= S_WR_DATA;
                end
                S_WR_DATA: begin
                    src_ptr <= src_ptr + src_step;
                    dst_ptr <= dst_ptr + dst_step;
                    ctl[CTL_CNT_LSB +: 11] <= cnt - CNT_ONE;
                    // pause writes progress back and frees the engine
                    state <= (last_item | ~keep_going) ?
                        S_WB_SRC : S_RD_DATA;
                end
                S_WB_SRC: state <= S_WB_DST;
                S_WB_DST: state <= S_WB_CTL;
                S_WB_CTL: state <= S_IDLE;
                S_IDLE: state <= S_IDLE;
            endcase
        end
    end
endmodule // mdmac_top

// ---- mdmac_checker.sv ----
// Purpose: port checks of the dma controller
// Assumes: single clock pclk, reset presetn
// Notes: err_seen follows the error flag from bus traffic
`timescale 1ns/10ps
module mdmac_checker
    import mdmac_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic [31:0] periph_done,
    input wire logic irq
);
    logic err_seen;
    // error seen on the bus, cleared by a software write
    wire bus_err = mem_req && mem_ack && mem_err;
    wire err_clr = psel && penable && pwrite && paddr == REG_ERR
        && pwdata != 32'h0;
    // ------------------------------------------------------------
    // flag mirror
    // ------------------------------------------------------------
    // set wins over clear, as in the block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_seen <= 1'b0;
        end else begin
            err_seen <= bus_err || (err_seen && !err_clr);
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    a_rdata_quiet: assert property (!(pready && !pwrite)
        |-> prdata == 0)
        else $error("stray read data");
    a_slverr_unal: assert property (psel && !penable && paddr[1:0] != 2'h0
        |=> pready && pslverr)
        else $error("unaligned not refused");
    a_req_hold: assert property (mem_req && !mem_ack |=> mem_req
        && $stable(mem_addr) && $stable(mem_we))
        else $error("request moved before ack");
    a_req_drop: assert property (mem_req && mem_ack |=> !mem_req)
        else $error("request held after ack");
    a_err_held: assert property (err_seen |-> irq)
        else $error("irq dropped with error set");
    a_done_pulse: assert property (|periph_done |=> !periph_done)
        else $error("done pulse too long");
    a_done_no_irq: assert property (|periph_done && !err_seen
        |-> !irq)
        else $error("peripheral done raised irq");
    a_irq_pulse: assert property ($rose(irq) && !err_seen && !bus_err
        |=> !irq)
        else $error("done irq not a pulse");
    c_bus_err: cover property (bus_err);
    c_done: cover property (periph_done != 0);
    c_irq: cover property ($rose(irq));
endmodule // mdmac_checker

// ---- mdmac_mem.sv ----
// Purpose: behavioural memory on the far side of the dma master
// Assumes: request held until ack, one ack per request
// Notes: word accesses only; idle read data toggles every cycle
`timescale 1ns/10ps
module mdmac_mem (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [1:0] mem_size,
    output logic [31:0] mem_rdata,
    output logic mem_ack,
    output logic mem_err,
    input wire logic slow,
    input wire logic fail
);
    logic [31:0] ram [0:511]; // ram holds table and task lists
    int wait_n;
    // ack after 0 or 3 wait cycles; released data never holds
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            mem_err <= 1'b0;
            mem_rdata <= 32'h0;
            wait_n <= 0;
        end else begin
            mem_ack <= 1'b0;
            mem_err <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                if (wait_n < (slow ? 3 : 0)) begin
                    wait_n <= wait_n + 1;
                end else begin
                    wait_n <= 0;
                    mem_ack <= 1'b1;
                    mem_err <= fail;
                    if (mem_we) begin
                        ram[mem_addr[10:2]] <= mem_wdata;
                    end else begin
                        mem_rdata <= ram[mem_addr[10:2]];
                    end
                end
            end
        end
    end
endmodule // mdmac_mem

// ---- mdmac_bench.sv ----
// Purpose: self-checking bench of the dma controller
// Assumes: apb master per contract, memory model on far side
// Notes: table at 0x400, model word 256
`timescale 1ns/10ps
module mdmac_bench
    import mdmac_pkg::*;
;
    localparam int TBL = 256;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, dma_req = 32'h0;
    logic slow = 1'b0, fail = 1'b0;
    logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata, periph_done;
    logic pready, pslverr, mem_req, mem_we, mem_ack, mem_err, irq;
    logic [1:0] mem_size;
    logic [31:0] rdv;
    logic sev;
    int bad_count = 0, comparisons = 0, cyc = 0, irq_n = 0, pd_n = 0;
    mdmac_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_size(mem_size), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .mem_err(mem_err), .dma_req(dma_req),
        .periph_done(periph_done), .irq(irq));
    mdmac_mem mem_u (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_size(mem_size), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .mem_err(mem_err), .slow(slow), .fail(fail));
    always #2.5 pclk = ~pclk;
    // irq cycles, completions and the hang limit
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        irq_n <= irq_n + int'(irq === 1'b1);
        pd_n <= pd_n + int'((|periph_done) === 1'b1);
        if (cyc == 30000) begin
            bad_count++;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        sev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask
    function automatic logic [31:0] pat(int i);
        return 32'h5A5A_0000 + 32'(i);
    endfunction
    // word items, word steps on both sides
    function automatic logic [31:0] ctl(logic [2:0] m, logic [10:0] n);
        logic [31:0] w;
        w = {30'h0, SIZE_WORD};
        return (w << CTL_DINC_LSB) | (w << CTL_SINC_LSB) |
            (w << CTL_SIZE_LSB) | ({21'h0, n} << CTL_CNT_LSB) | {29'h0, m};
    endfunction
    task automatic put(input int i, input logic [31:0] s, d, c);
        mem_u.ram[TBL + i * 4] = s;
        mem_u.ram[TBL + i * 4 + 1] = d;
        mem_u.ram[TBL + i * 4 + 2] = c;
    endtask
    task automatic wait_off(input int b);
        for (int k = 0; k < 100; k++) begin
            apb(1'b0, REG_ENA_SET, 32'h0);
            if (rdv[b] === 1'b0) break;
        end
        repeat (4) @(posedge pclk);
    endtask
    task automatic got4(input int w);
        for (int i = 0; i < 4; i++) chk(mem_u.ram[w + i], pat(i));
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rc(REG_CFG, 32'h0);
        rc(REG_ENA_SET, 32'h0);
        rc(REG_ERR, 32'h0);
        wr(REG_BASE, 32'h0000_0400);
        rc(REG_BASE, 32'h0000_0400);
        rc(REG_ALTBASE, 32'h0000_0600);
        wr(REG_PRIO_SET, 32'h0000_00A5);
        wr(REG_PRIO_CLR, 32'h0000_0005);
        rc(REG_PRIO_SET, 32'h0000_00A0);
        apb(1'b0, 8'h3C, 32'h0);
        chk({31'h0, sev}, 32'h1);
        wr(8'h29, 32'h0000_0001);
        rc(REG_ENA_SET, 32'h0);
    endtask
    task automatic t_sw();
        int i0;
        put(3, 32'h0, 32'h100, ctl(MODE_AUTO, 11'h004));
        wr(REG_ENA_SET, 32'h8);
        wr(REG_SWREQ, 32'h8);
        repeat (40) @(posedge pclk);
        chk(mem_u.ram[64], 32'h0);
        i0 = irq_n;
        wr(REG_CFG, 32'h1);
        wait_off(3);
        got4(64);
        chk(mem_u.ram[TBL + 12], 32'h10);
        chk(mem_u.ram[TBL + 13], 32'h110);
        chk(mem_u.ram[TBL + 14], ctl(MODE_STOP, CNT_ZERO));
        rc(REG_REMAIN, {13'h0000, MODE_AUTO, 5'h03, CNT_ZERO});
        chk(32'(irq_n - i0), 32'h1);
        rc(REG_CFG, 32'h1);
    endtask
    task automatic t_per();
        int i0, p0;
        slow <= 1'b1;
        put(7, 32'h0, 32'h180, ctl(MODE_BASIC, 11'h004));
        wr(REG_ENA_SET, 32'h80);
        rc(REG_ENA_SET, 32'h80);
        wr(REG_ENA_CLR, 32'h80);
        rc(REG_ENA_SET, 32'h0);
        dma_req <= 32'h80;
        repeat (40) @(posedge pclk);
        chk(mem_u.ram[96], 32'h0);
        dma_req <= 32'h0;
        wr(REG_ENA_SET, 32'h80);
        repeat (40) @(posedge pclk);
        chk(mem_u.ram[96], 32'h0);
        i0 = irq_n;
        p0 = pd_n;
        dma_req <= 32'h80;
        wait_off(7);
        dma_req <= 32'h0;
        got4(96);
        chk(32'(pd_n - p0), 32'h1);
        chk(32'(irq_n - i0), 32'h0);
        slow <= 1'b0;
    endtask
    task automatic t_alt();
        put(4, 32'h0, 32'h0, ctl(MODE_STOP, CNT_ZERO));
        put(36, 32'h0, 32'h200, ctl(MODE_PINGPONG, 11'h004));
        wr(REG_ALT_SET, 32'h10);
        rc(REG_ALT_SET, 32'h10);
        wr(REG_ENA_SET, 32'h10);
        wr(REG_SWREQ, 32'h10);
        for (int k = 0; k < 300; k++) begin
            if (mem_u.ram[TBL + 146] === ctl(MODE_STOP, CNT_ZERO)) break;
            @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
        got4(128);
        rc(REG_ALT_SET, 32'h0);
        wr(REG_ENA_CLR, 32'h10);
    endtask
    task automatic t_err();
        fail <= 1'b1;
        put(9, 32'h0, 32'h300, ctl(MODE_AUTO, 11'h004));
        wr(REG_ENA_SET, 32'h200);
        wr(REG_SWREQ, 32'h200);
        wait_off(9);
        fail <= 1'b0;
        rc(REG_ERR, 32'h1);
        repeat (8) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        chk(mem_u.ram[TBL + 38], ctl(MODE_AUTO, 11'h004));
        wr(REG_ERR, 32'h1);
        rc(REG_ERR, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
    endtask
    // reset, then scenarios in order
    initial begin
        for (int i = 0; i < 512; i++) mem_u.ram[i] = (i < 4) ? pat(i) : 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_sw();
        t_per();
        t_alt();
        t_err();
        wr(REG_CFG, 32'h0);
        rc(REG_CFG, 32'h0);
        close_out();
    end
endmodule // mdmac_bench
bind mdmac_top mdmac_checker chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_err(mem_err),
    .periph_done(periph_done), .irq(irq));
